/* File: hw/reload_timer_pkg.sv */
package reload_timer_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses on the apb slave)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL   = 8'hc8;  // timer_two_control
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hcc;  // timer_two_mode_control
  localparam logic [7:0] ADDR_COUNT_LO  = 8'hd0;  // count_low_byte
  localparam logic [7:0] ADDR_COUNT_HI  = 8'hd4;  // count_high_byte
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hd8;  // reload_low_byte
  localparam logic [7:0] ADDR_RELOAD_HI = 8'hdc;  // reload_high_byte

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int BIT_OVF    = 7;
  localparam int BIT_EXT    = 6;
  localparam int BIT_RXBAUD = 5;
  localparam int BIT_TXBAUD = 4;
  localparam int BIT_TRGEN  = 3;
  localparam int BIT_RUN    = 2;
  localparam int BIT_CSRC   = 1;
  localparam int BIT_CAPSEL = 0;
  // mode control fields
  localparam int BIT_CLKOE  = 1;
  localparam int BIT_DOWN_COUNT_ENABLE   = 0;

  localparam logic [7:0]  CONTROL_RST  = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [15:0] COUNT_TOP    = 16'hffff;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // timing: count prescale (oscillator / 2)
  // ----------------------------------------------------------------------
  localparam int OSC_DIVIDE = 2;

  typedef enum logic [1:0] {
    MODE_RELOAD  = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_BAUD    = 2'b10,
    MODE_CLKOUT  = 2'b11
  } timer_mode_e;

  typedef struct packed {
    logic tx_tick;
    logic rx_tick;
  } baud_ticks_s;

endpackage

/* File: hw/reload_timer_clock_out.sv */
// Operation
// - clock-out output has 50 percent duty
// - clock-out counts at half oscillator rate
// - counter reruns from preload to overflow
// - overflow copies reload pair into count, except in capture mode
// - no overflow interrupt in clock-out mode
// - output freq osc over 4*(65536-reload)
// - generated clock driven onto count pin while bit 1 clear
// - clock-out enable feeds divide-by-two stage
// - timer select clear counts half oscillator
// - baud and clock-out share reload pair
// - mode decoded from baud, capture, clockout
// - overflow flag set unless baud selected
// - external flag set by enabled trigger
// - bit 5 picks receive baud source
// - bit 4 picks transmit baud source
// - trigger enable gates trigger pin edges
// - bit 1 selects internal or pin count
// - capture select, ignored during baud
// - down-count follows trigger pin level
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module reload_timer_clock_out
  import reload_timer_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_clock_pin_i,
  output logic             count_clock_pin_o,
  output logic             count_clock_pin_oe,
  input  wire logic        trigger_pin,
  input  wire logic        other_timer_tick,
  output baud_ticks_s      baud_ticks,
  output logic             irq_request
);

  // ----------------------------------------------------------------------
  // registers and shared state
  // ----------------------------------------------------------------------
  logic [7:0]  control_q;
  logic [7:0]  mode_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic        divider_q;
  logic        presc_q;
  logic [2:0]  cnt_pin_sync_q;
  logic [2:0]  trg_sync_q;
  logic        own_tick_q;
  timer_mode_e mode;

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  function automatic timer_mode_e decode_mode(input logic [7:0] ctl, input logic [7:0] md);
    if (ctl[BIT_RXBAUD] || ctl[BIT_TXBAUD]) begin
      decode_mode = MODE_BAUD;
    end else if (!ctl[BIT_CAPSEL] && md[BIT_CLKOE]) begin
      decode_mode = MODE_CLKOUT;
    end else if (ctl[BIT_CAPSEL] && !md[BIT_CLKOE]) begin
      decode_mode = MODE_CAPTURE;
    end else begin
      decode_mode = MODE_RELOAD;
    end
  endfunction

  assign mode = decode_mode(control_q, mode_q);

  wire logic baud_sel   = control_q[BIT_RXBAUD] | control_q[BIT_TXBAUD];
  wire logic clkout_on  = mode_q[BIT_CLKOE] & ~control_q[BIT_CAPSEL];
  wire logic pin_source = control_q[BIT_CSRC] & ~clkout_on;

  // ----------------------------------------------------------------------
  // pin synchronisers; bit 0 is read only by bit 1
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_pin_sync_q <= 3'h7;
      trg_sync_q     <= 3'h7;
    end else begin
      cnt_pin_sync_q <= {cnt_pin_sync_q[1:0], count_clock_pin_i};
      trg_sync_q     <= {trg_sync_q[1:0], trigger_pin};
    end
  end

  wire logic pin_fall  = cnt_pin_sync_q[2] & ~cnt_pin_sync_q[1];
  wire logic trg_fall  = trg_sync_q[2] & ~trg_sync_q[1];
  wire logic trg_level = trg_sync_q[1];

  // ----------------------------------------------------------------------
  // half-oscillator prescaler
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      presc_q <= 1'b0;
    end else begin
      presc_q <= ~presc_q;
    end
  end

  // timer input is every second system clock; pin input is falling edges
  wire logic count_en = control_q[BIT_RUN] &
                        (pin_source ? pin_fall : presc_q);

  wire logic trig_ev  = control_q[BIT_TRGEN] & trg_fall & ~baud_sel;
  wire logic down_mode = mode_q[BIT_DOWN_COUNT_ENABLE] & (mode == MODE_RELOAD);
  wire logic count_dn  = down_mode & ~trg_level;
  wire logic overflow  = count_en & ~count_dn & (count_q == COUNT_TOP);
  wire logic underflow = count_en & count_dn & (count_q == reload_q);
  wire logic roll      = overflow | underflow;

  // ----------------------------------------------------------------------
  // apb write decode
  // ----------------------------------------------------------------------
  wire logic wr_en  = psel & penable & pwrite;
  wire logic wr_ctl = wr_en & (paddr == ADDR_CONTROL);
  wire logic wr_md  = wr_en & (paddr == ADDR_MODE_CTRL);
  wire logic wr_clo = wr_en & (paddr == ADDR_COUNT_LO);
  wire logic wr_chi = wr_en & (paddr == ADDR_COUNT_HI);
  wire logic wr_rlo = wr_en & (paddr == ADDR_RELOAD_LO);
  wire logic wr_rhi = wr_en & (paddr == ADDR_RELOAD_HI);

  // ----------------------------------------------------------------------
  // control register; hardware set wins over a software clear
  // ----------------------------------------------------------------------
  wire logic set_ovf = roll & ~baud_sel;
  wire logic set_ext = trig_ev & ~down_mode |
                       (down_mode & roll);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      control_q <= CONTROL_RST;
    end else begin
      if (wr_ctl) begin
        control_q <= pwdata[7:0];
      end
      if (set_ovf) begin
        control_q[BIT_OVF] <= 1'b1;
      end
      if (down_mode && roll) begin
        // direction-change bit toggles for 17-bit resolution
        control_q[BIT_EXT] <= ~(wr_ctl ? pwdata[BIT_EXT] : control_q[BIT_EXT]);
      end else if (set_ext) begin
        control_q[BIT_EXT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q <= MODE_RST;
    end else if (wr_md) begin
      mode_q <= {6'h00, pwdata[1:0]};
    end
  end

  // ----------------------------------------------------------------------
  // reload / capture pair
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reload_q <= 16'h0000;
    end else begin
      if (wr_rlo) begin
        reload_q[7:0] <= pwdata[7:0];
      end
      if (wr_rhi) begin
        reload_q[15:8] <= pwdata[7:0];
      end
      if (mode == MODE_CAPTURE && trig_ev) begin
        reload_q <= count_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // count register; software must preload before starting
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q <= 16'h0000;
    end else if (wr_clo || wr_chi) begin
      if (wr_clo) begin
        count_q[7:0] <= pwdata[7:0];
      end
      if (wr_chi) begin
        count_q[15:8] <= pwdata[7:0];
      end
    end else if (overflow && mode != MODE_CAPTURE) begin
      count_q <= reload_q;
    end else if (underflow) begin
      count_q <= COUNT_TOP;
    end else if (mode == MODE_RELOAD && trig_ev && !down_mode) begin
      count_q <= reload_q;
    end else if (count_en) begin
      count_q <= count_dn ? count_q - 16'h0001 : count_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // divide-by-two clock output; half period equals one overflow period
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      divider_q <= 1'b0;
    end else if (!mode_q[BIT_CLKOE]) begin
      divider_q <= 1'b0;
    end else if (overflow) begin
      divider_q <= ~divider_q;
    end
  end

  assign count_clock_pin_o  = divider_q;
  assign count_clock_pin_oe = clkout_on & ~control_q[BIT_CSRC];

  // ----------------------------------------------------------------------
  // baud ticks to the serial port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      own_tick_q <= 1'b0;
    end else begin
      own_tick_q <= overflow;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      baud_ticks <= '0;
    end else begin
      baud_ticks.rx_tick <= control_q[BIT_RXBAUD] ? own_tick_q : other_timer_tick;
      baud_ticks.tx_tick <= control_q[BIT_TXBAUD] ? own_tick_q : other_timer_tick;
    end
  end

  // interrupt request level to the system controller; overflow masked in clock-out
  assign irq_request = (control_q[BIT_OVF] & (mode != MODE_CLKOUT)) |
                       (control_q[BIT_EXT] & ~mode_q[BIT_DOWN_COUNT_ENABLE]);

  // ----------------------------------------------------------------------
  // apb read path; zero wait states
  // ----------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= UNMAPPED_RD;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CONTROL:   prdata <= {24'h0, control_q};
        ADDR_MODE_CTRL: prdata <= {24'h0, mode_q};
        ADDR_COUNT_LO:  prdata <= {24'h0, count_q[7:0]};
        ADDR_COUNT_HI:  prdata <= {24'h0, count_q[15:8]};
        ADDR_RELOAD_LO: prdata <= {24'h0, reload_q[7:0]};
        ADDR_RELOAD_HI: prdata <= {24'h0, reload_q[15:8]};
        default:        prdata <= UNMAPPED_RD;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_reload_on_ovf: assert property (@(posedge clk_sys) disable iff (sys_rst)
    overflow && mode == MODE_CLKOUT && !(wr_clo || wr_chi) |=> count_q == $past(reload_q))
    else $error("count not reloaded on overflow");
  a_div_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    overflow && mode_q[BIT_CLKOE] |=> divider_q != $past(divider_q))
    else $error("divider did not toggle");
  a_div_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !overflow && mode_q[BIT_CLKOE] |=> $stable(divider_q))
    else $error("divider changed without overflow");
  a_no_irq_clk: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode == MODE_CLKOUT && !control_q[BIT_EXT] |-> !irq_request)
    else $error("interrupt in clock-out mode");
  a_half_rate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    count_en && !pin_source |=> !count_en)
    else $error("count faster than half rate");
  a_ovf_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    overflow && !baud_sel |=> control_q[BIT_OVF])
    else $error("overflow flag not set");
  a_pin_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode == MODE_CLKOUT && !control_q[BIT_CSRC] |-> count_clock_pin_oe)
    else $error("clock not driven on pin");
  a_trig_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    trg_fall && !control_q[BIT_TRGEN] && mode == MODE_CAPTURE && !wr_rlo && !wr_rhi
      |=> $stable(reload_q))
    else $error("capture without trigger enable");
  a_tx_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
    control_q[BIT_TXBAUD] && $past(control_q[BIT_TXBAUD]) && own_tick_q |=> baud_ticks.tx_tick)
    else $error("transmit tick missing");

  // ----------------------------------------------------------------------
  // multi-step checks built from named sequences
  // ----------------------------------------------------------------------

  // a software byte write in the same cycle would mask the reload
  sequence s_ovf_reload;
    overflow && mode != MODE_CAPTURE && !(wr_clo || wr_chi);
  endsequence

  // down counting reached the reload floor with no software write
  sequence s_floor_hit;
    underflow && !(wr_clo || wr_chi);
  endsequence

  // receive path selected for two cycles, so the tick is ours
  sequence s_rx_own;
    control_q[BIT_RXBAUD] && $past(control_q[BIT_RXBAUD]) && own_tick_q;
  endsequence

  // enabled trigger edge while in capture mode
  sequence s_capture_edge;
    mode == MODE_CAPTURE && trig_ev;
  endsequence

  // direction change in up/down mode, no software write to the flag
  sequence s_dir_change;
    down_mode && roll && !wr_ctl;
  endsequence

  a_auto_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ovf_reload |=> count_q == $past(reload_q))
    else $error("count not reloaded after overflow");
  a_floor_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_floor_hit |=> count_q == COUNT_TOP)
    else $error("count not set to top after underflow");
  a_ext_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_dir_change |=> control_q[BIT_EXT] != $past(control_q[BIT_EXT]))
    else $error("external flag did not toggle");
  a_rx_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_rx_own |=> baud_ticks.rx_tick)
    else $error("receive tick missing");
  a_capture_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_capture_edge |=> reload_q == $past(count_q))
    else $error("count not captured on trigger");

  // single-step checks on flags and decode
  a_ext_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    trig_ev && !down_mode |=> control_q[BIT_EXT])
    else $error("external flag not set");
  a_baud_no_ovf: assert property (@(posedge clk_sys) disable iff (sys_rst)
    baud_sel && !wr_ctl |=> $stable(control_q[BIT_OVF]))
    else $error("overflow flag moved in baud mode");
  a_baud_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    baud_sel |-> mode == MODE_BAUD)
    else $error("baud select not decoded");
  // the pin must stay an input whenever clock-out is off
  a_oe_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clkout_on |-> !count_clock_pin_oe)
    else $error("pin driven outside clock-out");

endmodule
`default_nettype wire

/* File: tb/timer_pins_model.sv */
`timescale 1ns/1ns
`default_nettype none
// far side of the timer: trigger source, count pin pull-up, other timer
module timer_pins_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic trig_level,
  output logic      trigger_pin,
  output logic      other_timer_tick,
  output logic      ext_level
);
  logic [3:0] div_q;
  // other timer overflows every 16 cycles, unlike our own tick rates
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign other_timer_tick = (div_q == 4'hf);
  // trigger follows the bench one cycle late, an unrelated source
  always_ff @(posedge clk_sys) begin
    trigger_pin <= trig_level;
  end
  // released count pin rests high through its pull-up
  assign ext_level = 1'b1;
endmodule
`default_nettype wire

/* File: tb/reload_timer_clock_out_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module reload_timer_clock_out_tb_top;
  import reload_timer_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite, trig_level;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pin_o, pin_oe, trigger_pin, other_timer_tick;
  logic        ext_level, irq_request;
  baud_ticks_s baud_ticks;
  int          mismatches, n_tests;
  // pin level: the block wins while it drives, else the pull-up
  wire logic   pin_wire = pin_oe ? pin_o : ext_level;

  reload_timer_clock_out u_reload_timer_clock_out (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_clock_pin_i(pin_wire),
    .count_clock_pin_o(pin_o), .count_clock_pin_oe(pin_oe),
    .trigger_pin(trigger_pin), .other_timer_tick(other_timer_tick),
    .baud_ticks(baud_ticks), .irq_request(irq_request));
  timer_pins_model u_timer_pins_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .trig_level(trig_level),
    .trigger_pin(trigger_pin), .other_timer_tick(other_timer_tick),
    .ext_level(ext_level));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; entered just after an edge, leaves just after one
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // stop, load reload pair and count, then start with ctl
  task automatic setup(input logic [15:0] rl, input logic [15:0] cnt, input logic [7:0] ctl);
    apb(1'b1, ADDR_CONTROL, 32'h0);
    apb(1'b1, ADDR_RELOAD_LO, {24'h0, rl[7:0]});
    apb(1'b1, ADDR_RELOAD_HI, {24'h0, rl[15:8]});
    apb(1'b1, ADDR_COUNT_LO, {24'h0, cnt[7:0]});
    apb(1'b1, ADDR_COUNT_HI, {24'h0, cnt[15:8]});
    apb(1'b1, ADDR_CONTROL, {24'h0, ctl});
  endtask

  task automatic t_reset();
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("control reset", rd, {24'h0, CONTROL_RST});
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped read", rd, UNMAPPED_RD);
    check("no slave error", {31'h0, pslverr}, 32'h0);
  endtask

  // down count with trigger low: floor hit loads top, flag toggles
  task automatic t_down();
    trig_level <= 1'b0;
    apb(1'b1, ADDR_MODE_CTRL, 32'h1);
    setup(16'h0010, 16'h0012, 8'h04);
    cycles(20);
    apb(1'b0, ADDR_COUNT_HI, 32'h0);
    check("down count top", rd, 32'hff);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("direction flag", {31'h0, rd[BIT_EXT]}, 32'h1);
    apb(1'b1, ADDR_MODE_CTRL, 32'h0);
    trig_level <= 1'b1;
  endtask

  // clock-out: measure high and low time after a settling period
  task automatic t_clkout();
    logic [15:0] tbl [2] = '{16'hfff0, 16'hfffe};
    int hi, lo, n;
    apb(1'b1, ADDR_MODE_CTRL, 32'h2);
    foreach (tbl[i]) begin
      setup(tbl[i], tbl[i], 8'h04);
      for (int p = 0; p < 2; p++) begin
        n = 0;
        while (pin_wire !== 1'b0 && n < 400) begin
          @(posedge clk_sys);
          n++;
        end
        while (pin_wire !== 1'b1 && n < 400) begin
          @(posedge clk_sys);
          n++;
        end
        hi = 0;
        lo = 0;
        while (pin_wire === 1'b1 && hi < 400) begin
          @(posedge clk_sys);
          hi++;
        end
        while (pin_wire === 1'b0 && lo < 400) begin
          @(posedge clk_sys);
          lo++;
        end
      end
      check("clkout high", hi, 2 * (32'h10000 - tbl[i]));
      check("clkout low", lo, 2 * (32'h10000 - tbl[i]));
      check("pin drive", {31'h0, pin_oe}, 32'h1);
      check("clkout irq", {31'h0, irq_request}, 32'h0);
    end
    apb(1'b1, ADDR_MODE_CTRL, 32'h0);
  endtask

  task automatic t_reload();
    setup(16'h1234, 16'hfffc, 8'h04);
    cycles(14);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("overflow flag", {31'h0, rd[BIT_OVF]}, 32'h1);
    check("overflow irq", {31'h0, irq_request}, 32'h1);
    apb(1'b0, ADDR_COUNT_HI, 32'h0);
    check("reloaded high", rd, 32'h12);
    apb(1'b1, ADDR_CONTROL, 32'h04);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("flag cleared", rd, 32'h04);
  endtask

  // own ticks every 8 cycles, other timer every 16
  task automatic t_baud();
    logic [7:0] ctl [2] = '{8'h14, 8'h24};
    int tx, rx;
    foreach (ctl[i]) begin
      setup(16'hfffc, 16'hfffc, ctl[i]);
      cycles(4);
      tx = 0;
      rx = 0;
      repeat (64) begin
        @(posedge clk_sys);
        tx += int'(baud_ticks.tx_tick === 1'b1);
        rx += int'(baud_ticks.rx_tick === 1'b1);
      end
      check("tx source", tx / 3, i == 0 ? 32'h2 : 32'h1);
      check("rx source", rx / 3, i == 0 ? 32'h1 : 32'h2);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check("baud no flag", {31'h0, rd[BIT_OVF]}, 32'h0);
    end
  endtask

  task automatic t_trigger();
    for (int en = 1; en >= 0; en--) begin
      setup(16'h0000, 16'h0000, en ? 8'h0d : 8'h05);
      trig_level <= 1'b1;
      cycles(6);
      trig_level <= 1'b0;
      cycles(8);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check("trigger flag", {31'h0, rd[BIT_EXT]}, en);
    end
  endtask

  initial begin
    sys_rst    = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    trig_level = 1'b1;
    cycles(6);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_clkout();
    t_reload();
    t_baud();
    t_trigger();
    t_down();
    conclude();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #(50 * 20000);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
